// ==== rtl/bus_idle_insert.sv ====
// External bus access sequencer with read-read idle-cycle insertion.
//
// What this block does
// - Reads switching spaces get the other-space idle count from bits 21..19.
// - Consecutive reads to one space get the same-space count from bits 18..16.
// - Codes 0..7 give 0,1,2,4,6,8,10,12 idle cycles; both reset to 3.
// - Bit 15 is reserved, reads zero; software writes zero.
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/100ps
module bus_idle_insert #(
  parameter int unsigned NUM_SPACES = 8,
  parameter int unsigned ADDR_W     = 26,
  parameter int unsigned DATA_W     = 32,
  parameter int unsigned ACC_CYCLES = bus_idle_pkg::ACCESS_CYCLES
) (
  input  wire logic                          clk_sys,
  input  wire logic                          sys_rst,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic                               pready,
  output logic [31:0]                        prdata,
  output logic                               pslverr,
  input  wire logic                          reqValid,
  output logic                               reqReady,
  input  wire logic                          reqWrite,
  input  wire logic [$clog2(NUM_SPACES)-1:0] reqSpace,
  input  wire logic [ADDR_W-1:0]             reqAddr,
  input  wire logic [DATA_W-1:0]             reqWdata,
  output logic                               rspValid,
  output logic [DATA_W-1:0]                  rspRdata,
  output logic [ADDR_W-1:0]                  memAddr,
  output logic [NUM_SPACES-1:0]              memCsN,
  output logic                               memRdN,
  output logic                               memWrN,
  output logic [DATA_W-1:0]                  memDataOut,
  output logic                               memDataOe,
  input  wire logic [DATA_W-1:0]             memDataIn
);

  localparam int unsigned SPACE_W = $clog2(NUM_SPACES);
  localparam logic [3:0]  ACC_LAST = 4'(ACC_CYCLES - 1);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_GAP,
    ST_ACCESS
  } phase_t;

  typedef struct packed {
    phase_t                phase;
    logic [3:0]            accCnt;
    logic [3:0]            idleCnt;
    logic [3:0]            need;
    logic                  lastRead;
    logic [SPACE_W-1:0]    lastSpace;
    logic                  write;
    logic [SPACE_W-1:0]    space;
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     wdata;
    logic [DATA_W-1:0]     rdata;
    logic                  rspValid;
    logic                  rdPend;
    logic                  pendRd;
    logic [NUM_SPACES-1:0] csN;
    logic                  rdN;
    logic                  wrN;
    logic                  oe;
    logic [DATA_W-1:0]     syncA;
    logic [DATA_W-1:0]     syncB;
  } state_t;

  state_t     s;
  state_t     next_s;
  logic [2:0] idleRdRdOtherSpace;
  logic [2:0] idleRdRdSameSpace;
  logic [31:0] statusWord;
  logic       lastAcc;
  logic [3:0] avail;
  logic [3:0] reqNeed;
  logic       prevRead;
  logic [SPACE_W-1:0] prevSpace;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  idle_cfg_regs u_regs (
    .clk_sys            (clk_sys),
    .sys_rst            (sys_rst),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .pready             (pready),
    .prdata             (prdata),
    .pslverr            (pslverr),
    .statusWord         (statusWord),
    .idleRdRdOtherSpace (idleRdRdOtherSpace),
    .idleRdRdSameSpace  (idleRdRdSameSpace)
  );

  always_comb begin
    statusWord = '0;
    statusWord[bus_idle_pkg::STAT_BUSY_BIT]   = (s.phase != ST_IDLE);
    statusWord[bus_idle_pkg::STAT_WAIT_BIT]   = (s.phase == ST_GAP);
    statusWord[bus_idle_pkg::STAT_LASTRD_BIT] = s.lastRead;
    statusWord[bus_idle_pkg::STAT_NEED_LSB +: bus_idle_pkg::IDLE_W] = s.need;
    statusWord[bus_idle_pkg::STAT_SPACE_LSB +: SPACE_W] = s.lastSpace;
  end

  // ----------------------------------------------------------------
  // Idle requirement for a new request
  // ----------------------------------------------------------------
  assign lastAcc  = (s.phase == ST_ACCESS) && (s.accCnt == ACC_LAST);
  assign reqReady = (s.phase == ST_IDLE) || lastAcc;

  // Idle cycles that will have passed if the next access started next cycle.
  assign avail = lastAcc ? bus_idle_pkg::IDLE_NONE
               : ((s.idleCnt >= bus_idle_pkg::IDLE_MAX) ? bus_idle_pkg::IDLE_MAX
                  : s.idleCnt + bus_idle_pkg::IDLE_ONE);

  always_comb begin
    reqNeed = bus_idle_pkg::IDLE_NONE;
    // A request taken in the last access cycle follows the access still running.
    prevRead  = lastAcc ? !s.write : s.lastRead;
    prevSpace = lastAcc ? s.space : s.lastSpace;
    if (!reqWrite && prevRead) begin
      if (reqSpace == prevSpace) begin
        reqNeed = bus_idle_pkg::idle_cycles(idleRdRdSameSpace);
      end else begin
        reqNeed = bus_idle_pkg::idle_cycles(idleRdRdOtherSpace);
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_s          = s;
    next_s.syncA    = memDataIn;
    next_s.syncB    = s.syncA;
    // Read data are taken one cycle after the access, once the synchroniser holds them.
    next_s.rspValid = s.rdPend;
    next_s.rdPend   = 1'b0;
    if (s.rdPend && s.pendRd) begin
      next_s.rdata = s.syncB;
    end
    if (s.phase != ST_ACCESS && s.idleCnt < bus_idle_pkg::IDLE_MAX) begin
      next_s.idleCnt = s.idleCnt + bus_idle_pkg::IDLE_ONE;
    end
    unique case (s.phase)
      ST_IDLE: begin
      end
      ST_GAP: begin
        if (avail >= s.need) begin
          next_s.phase  = ST_ACCESS;
          next_s.accCnt = '0;
        end
      end
      ST_ACCESS: begin
        next_s.accCnt = s.accCnt + 4'h1;
        if (lastAcc) begin
          next_s.phase     = ST_IDLE;
          next_s.idleCnt   = bus_idle_pkg::IDLE_NONE;
          next_s.lastRead  = !s.write;
          next_s.lastSpace = s.space;
          next_s.rdPend    = 1'b1;
          next_s.pendRd    = !s.write;
        end
      end
    endcase
    if (reqValid && reqReady) begin
      next_s.write  = reqWrite;
      next_s.space  = reqSpace;
      next_s.addr   = reqAddr;
      next_s.wdata  = reqWdata;
      next_s.need   = reqNeed;
      next_s.accCnt = '0;
      next_s.phase  = (avail >= reqNeed) ? ST_ACCESS : ST_GAP;
    end
    // Strobes are active only in the access phase.
    next_s.csN = '1;
    next_s.rdN = 1'b1;
    next_s.wrN = 1'b1;
    next_s.oe  = 1'b0;
    if (next_s.phase == ST_ACCESS) begin
      next_s.csN[next_s.space] = 1'b0;
      next_s.rdN = next_s.write;
      next_s.wrN = !next_s.write;
      next_s.oe  = next_s.write;
    end
    if (sys_rst) begin
      next_s          = '0;
      next_s.phase    = ST_IDLE;
      next_s.idleCnt  = bus_idle_pkg::IDLE_MAX;
      next_s.csN      = '1;
      next_s.rdN      = 1'b1;
      next_s.wrN      = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    s <= next_s;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rspValid   = s.rspValid;
  assign rspRdata   = s.rdata;
  assign memAddr    = s.addr;
  assign memCsN     = s.csN;
  assign memRdN     = s.rdN;
  assign memWrN     = s.wrN;
  assign memDataOut = s.wdata;
  assign memDataOe  = s.oe;

endmodule : bus_idle_insert

// ==== rtl/idle_cfg_regs.sv ====
// APB slave holding the idle-cycle configuration and reading back status.
`timescale 1ns/100ps
module idle_cfg_regs (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [31:0] statusWord,
  output logic [2:0]       idleRdRdOtherSpace,
  output logic [2:0]       idleRdRdSameSpace
);

  typedef struct packed {
    logic [2:0]  other;
    logic [2:0]  same;
    logic [31:0] rdata;
    logic        err;
  } regs_t;

  regs_t r;
  regs_t next_r;
  logic  setup;
  logic  access;
  logic  hitCfg;
  logic  hitStat;

  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign hitCfg  = (paddr == bus_idle_pkg::CFG_OFFSET);
  assign hitStat = (paddr == bus_idle_pkg::STATUS_OFFSET);

  // ----------------------------------------------------------------
  // Register update
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    if (setup) begin
      next_r.err   = !(hitCfg || hitStat);
      next_r.rdata = '0;
      if (!pwrite && hitCfg) begin
        next_r.rdata[bus_idle_pkg::OTHER_MSB:bus_idle_pkg::OTHER_LSB] = r.other;
        next_r.rdata[bus_idle_pkg::SAME_MSB:bus_idle_pkg::SAME_LSB]   = r.same;
        next_r.rdata[bus_idle_pkg::RSVD_BIT] = 1'b0;
      end else if (!pwrite && hitStat) begin
        next_r.rdata = statusWord;
      end
    end
    if (access && pwrite && hitCfg) begin
      next_r.other = pwdata[bus_idle_pkg::OTHER_MSB:bus_idle_pkg::OTHER_LSB];
      next_r.same  = pwdata[bus_idle_pkg::SAME_MSB:bus_idle_pkg::SAME_LSB];
    end
    if (sys_rst) begin
      next_r.other = bus_idle_pkg::IDLE_CODE_RESET;
      next_r.same  = bus_idle_pkg::IDLE_CODE_RESET;
      next_r.rdata = '0;
      next_r.err   = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    r <= next_r;
  end

  assign pready             = access;
  assign prdata             = r.rdata;
  assign pslverr            = access && r.err;
  assign idleRdRdOtherSpace = r.other;
  assign idleRdRdSameSpace  = r.same;

endmodule : idle_cfg_regs

// ==== shared/bus_idle_pkg.sv ====
// Shared constants for the read-read idle-cycle insertion block.
package bus_idle_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned APB_AW          = 8;
  localparam logic [7:0]  CFG_OFFSET      = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET   = 8'h04;

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  localparam int unsigned OTHER_MSB       = 21;
  localparam int unsigned OTHER_LSB       = 19;
  localparam int unsigned SAME_MSB        = 18;
  localparam int unsigned SAME_LSB        = 16;
  localparam int unsigned RSVD_BIT        = 15;
  localparam logic [2:0]  IDLE_CODE_RESET = 3'h3;

  // ----------------------------------------------------------------
  // Status fields
  // ----------------------------------------------------------------
  localparam int unsigned STAT_BUSY_BIT   = 0;
  localparam int unsigned STAT_WAIT_BIT   = 1;
  localparam int unsigned STAT_LASTRD_BIT = 2;
  localparam int unsigned STAT_NEED_LSB   = 4;
  localparam int unsigned STAT_SPACE_LSB  = 8;

  // ----------------------------------------------------------------
  // Idle counting
  // ----------------------------------------------------------------
  localparam int unsigned IDLE_W          = 4;
  localparam logic [3:0]  IDLE_NONE       = 4'h0;
  localparam logic [3:0]  IDLE_ONE        = 4'h1;
  localparam logic [3:0]  IDLE_MAX        = 4'hC;
  localparam int unsigned ACCESS_CYCLES   = 2;

  // Converts an idle-cycle code into the number of idle cycles.
  function automatic logic [3:0] idle_cycles(input logic [2:0] code);
    logic [3:0] n;
    unique case (code)
      3'h0: n = 4'h0;
      3'h1: n = 4'h1;
      3'h2: n = 4'h2;
      3'h3: n = 4'h4;
      3'h4: n = 4'h6;
      3'h5: n = 4'h8;
      3'h6: n = 4'hA;
      3'h7: n = 4'hC;
    endcase
    return n;
  endfunction : idle_cycles

endpackage : bus_idle_pkg

// ==== verification/bus_idle_insert_asserts.sv ====
// Checker for the read-read idle-cycle insertion block.
`timescale 1ns/100ps
module bus_idle_insert_asserts #(
  parameter int unsigned NUM_SPACES = 8
) (
  input wire logic                  clk_sys,
  input wire logic                  sys_rst,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire logic                  pready,
  input wire logic [31:0]           prdata,
  input wire logic [NUM_SPACES-1:0] memCsN,
  input wire logic                  memRdN,
  input wire logic                  memWrN
);
  localparam logic [31:0] GAPS = 32'hCA864210;
  logic [2:0]            oc, sc;
  logic [3:0]            gap;
  logic                  lastRd, prevRdN, rdStart, cfgRd;
  logic [NUM_SPACES-1:0] lastCs, prevCs;
  assign rdStart = !memRdN && (prevRdN || memCsN != prevCs);
  assign cfgRd = psel && penable && !pwrite && paddr == bus_idle_pkg::CFG_OFFSET;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      oc <= 3'h3;
      sc <= 3'h3;
      gap <= 4'hF;
      lastRd <= 1'b0;
      prevRdN <= 1'b1;
      prevCs <= '1;
      lastCs <= '1;
    end else begin
      if (psel && penable && pwrite && pready && paddr == bus_idle_pkg::CFG_OFFSET) begin
        oc <= pwdata[21:19];
        sc <= pwdata[18:16];
      end
      gap <= (!memRdN || !memWrN) ? 4'h0 : gap + {3'h0, gap != 4'hF};
      if (!memRdN) begin
        lastRd <= 1'b1;
        lastCs <= memCsN;
      end
      if (!memWrN) lastRd <= 1'b0;
      prevRdN <= memRdN;
      prevCs <= memCsN;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  other_gap_a: assert property (rdStart && lastRd && memCsN != lastCs |->
    gap >= GAPS[{oc, 2'b00} +: 4]) else $error("short gap between reads of two spaces");
  same_gap_a: assert property (rdStart && lastRd && memCsN == lastCs |->
    gap >= GAPS[{sc, 2'b00} +: 4]) else $error("short gap between reads of one space");
  cfg_value_a: assert property (cfgRd |-> prdata[21:16] == {oc, sc})
    else $error("idle code readback wrong");
  rsvd_zero_a: assert property (cfgRd |-> !prdata[15])
    else $error("reserved bit read as one");
  one_select_a: assert property ($onehot0(~memCsN))
    else $error("several selects active");
  strobe_select_a: assert property (!memRdN || !memWrN |-> $onehot(~memCsN))
    else $error("strobe without one select");
endmodule : bus_idle_insert_asserts
bind bus_idle_insert bus_idle_insert_asserts #(.NUM_SPACES(NUM_SPACES)) u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .memCsN(memCsN),
  .memRdN(memRdN), .memWrN(memWrN));

// ==== verification/bus_idle_insertion_tb.sv ====
// Testbench for the read-read idle-cycle insertion block.
`timescale 1ns/100ps
module bus_idle_insertion_tb;
  localparam int          ACC  = bus_idle_pkg::ACCESS_CYCLES;
  localparam logic [31:0] GAPS = 32'hCA864210;
  logic        clk_sys = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, memCsN;
  logic [31:0] pwdata = 32'h0, reqWdata = 32'h0, prdata, rd, rspRdata, memDataOut, memDataIn;
  logic        reqValid = 1'b0, reqWrite = 1'b0, pready, pslverr, err, reqReady, rspValid;
  logic        memRdN, memWrN, memDataOe;
  logic [2:0]  reqSpace = 3'h0, oc, sc;
  logic [25:0] reqAddr = 26'h0, memAddr;
  int          num_errors = 0, checks_done = 0, cyc = 0, t1, t2, t3;
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  bus_idle_insert u_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite), .reqSpace(reqSpace),
    .reqAddr(reqAddr), .reqWdata(reqWdata), .rspValid(rspValid), .rspRdata(rspRdata),
    .memAddr(memAddr), .memCsN(memCsN), .memRdN(memRdN), .memWrN(memWrN),
    .memDataOut(memDataOut), .memDataOe(memDataOe), .memDataIn(memDataIn));
  mem_model u_mem (.clk_sys(clk_sys), .memAddr(memAddr), .memCsN(memCsN), .memRdN(memRdN),
    .memDataIn(memDataIn));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Holds a request until it is taken; the caller releases it.
  task automatic req(input logic wr, input logic [2:0] sp);
    logic rdy;
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqSpace <= sp;
    reqAddr <= {23'h0, sp};
    reqWdata <= 32'h5A5A0000;
    do begin
      @(negedge clk_sys);
      rdy = reqReady;
      @(posedge clk_sys);
    end while (rdy !== 1'b1);
  endtask : req
  // Returns the cycle in which the next strobe is seen low.
  task automatic wait_acc(output int t);
    @(negedge clk_sys);
    while (memRdN !== 1'b0 && memWrN !== 1'b0) @(negedge clk_sys);
    t = cyc;
    if (memWrN === 1'b0) begin
      chk("write data", memDataOut, 32'h5A5A0000);
      chk("write drive", {31'h0, memDataOe}, 32'h1);
    end
    @(posedge clk_sys);
  endtask : wait_acc
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    apb(1'b0, bus_idle_pkg::CFG_OFFSET, 32'h0, rd, err);
    chk("cfg reset", rd, 32'h001B0000);
    apb(1'b1, bus_idle_pkg::CFG_OFFSET, 32'h002A8000, rd, err);
    apb(1'b0, bus_idle_pkg::CFG_OFFSET, 32'h0, rd, err);
    chk("cfg readback", rd, 32'h002A0000);
    apb(1'b0, 8'h08, 32'h0, rd, err);
    chk("unmapped error", {31'h0, err}, 32'h1);
    req(1'b0, 3'h2);
    reqValid <= 1'b0;
    @(negedge clk_sys);
    while (rspValid !== 1'b1) @(negedge clk_sys);
    chk("read data", rspRdata, 32'h2);
    for (int c = 0; c < 8; c++) begin
      for (int s = 0; s < 2; s++) begin
        oc = 3'(c);
        sc = 3'(7 - c);
        apb(1'b1, bus_idle_pkg::CFG_OFFSET, {10'h0, oc, sc, 16'h0}, rd, err);
        req(1'b0, 3'h1);
        wait_acc(t1);
        req(1'b0, (s != 0) ? 3'h1 : 3'h2);
        wait_acc(t2);
        reqValid <= 1'b0;
        if (s != 0) chk("same gap", 32'(t2 - t1), 32'(ACC + int'(GAPS[{sc, 2'b00} +: 4])));
        else chk("other gap", 32'(t2 - t1), 32'(ACC + int'(GAPS[{oc, 2'b00} +: 4])));
      end
    end
    apb(1'b1, bus_idle_pkg::CFG_OFFSET, 32'h003F0000, rd, err);
    req(1'b0, 3'h1);
    wait_acc(t1);
    req(1'b1, 3'h1);
    wait_acc(t2);
    req(1'b0, 3'h1);
    wait_acc(t3);
    reqValid <= 1'b0;
    chk("read to write", 32'(t2 - t1), 32'(ACC));
    chk("write between", 32'(t3 - t2), 32'(ACC));
    repeat (8) @(posedge clk_sys);
    end_of_test();
  end
  initial begin
    repeat (4000) @(posedge clk_sys);
    num_errors++;
    end_of_test();
  end
endmodule : bus_idle_insertion_tb

// ==== verification/mem_model.sv ====
// External memory answering reads on the data pins.
`timescale 1ns/100ps
module mem_model (
  input  wire logic        clk_sys,
  input  wire logic [25:0] memAddr,
  input  wire logic [7:0]  memCsN,
  input  wire logic        memRdN,
  output logic [31:0]      memDataIn
);
  logic [31:0] lastData = 32'h0;
  always_ff @(posedge clk_sys) lastData <= memDataIn;
  // Released pins show a value that changes every cycle.
  assign memDataIn = (!memRdN && memCsN != 8'hFF) ? {6'h0, memAddr} : ~lastData;
endmodule : mem_model
